//--- hw/ctfs_top.v
// Channel transfer-function select and restart control
`timescale 1ns/1ps
`default_nettype none
`include "ctfs_defs.vh"
module ctfs_top #(
  parameter SETTLE_CYC = `CTFS_SETTLE_US * `CTFS_CLK_MHZ
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [1:0]  tf_wr_sel,
  input  wire        tf_wr_en,
  input  wire [7:0]  tf_wr_data,
  input  wire        auto_sequence,
  input  wire        differential_select,
  input  wire [1:0]  cal_mode_sel,
  input  wire [1:0]  input_pair_sel,
  input  wire        conv_done,
  input  wire [17:0] filter_result,
  output reg  [7:0]  channel_transfer_one,
  output reg  [7:0]  channel_transfer_two,
  output reg  [7:0]  channel_transfer_three,
  output reg  [2:0]  scan_pos,
  output reg  [1:0]  active_reg_sel,
  output reg         forbidden,
  output reg  [7:0]  pga_gain,
  output reg         unipolar,
  output reg         dac_connect,
  output reg         dac_negative,
  output reg  [10:0] dac_tenths_pct,
  output reg  [2:0]  channel_tag,
  output reg         cal_channel,
  output reg         mod_reset,
  output reg         data_ready_n,
  output reg  [17:0] result_data
);
  localparam ST_RUN    = 1'b0;
  localparam ST_SETTLE = 1'b1;
  localparam [15:0] SETTLE_W = SETTLE_CYC;

  reg        state_r;
  reg [15:0] settle_cnt_r;
  reg [1:0]  sel_nxt;
  reg        forbid_nxt;
  reg [7:0]  tf_act;
  reg [2:0]  tag_nxt;
  reg        cal_nxt;
  reg [2:0]  last_pos;
  reg [6:0]  ctrl_prev_r;
  reg        pol_hold_r;
  wire [7:0] ctrl_now;
  wire       wr_active;
  wire       ctrl_change;

  // Active index from mode and scan position
  always @* begin
    sel_nxt    = `CTFS_SEL_NONE;
    forbid_nxt = 1'b0;
    tag_nxt    = 3'h0;
    cal_nxt    = 1'b0;
    last_pos   = 3'h0;
    if (cal_mode_sel == 2'h3) begin
      forbid_nxt = 1'b1;
    end else if (auto_sequence) begin
      if (differential_select) begin
        last_pos = (cal_mode_sel != `CTFS_MODE_NORMAL) ? 3'h4 : 3'h2;
        if (scan_pos < 3'h3) begin
          sel_nxt = scan_pos[1:0] + 2'h1;
          tag_nxt = 3'h4 + scan_pos;
        end else begin
          sel_nxt = `CTFS_SEL_THREE;
          tag_nxt = 3'h7;
          cal_nxt = 1'b1;
        end
      end else begin
        last_pos = (cal_mode_sel != `CTFS_MODE_NORMAL) ? 3'h6 : 3'h4;
        case (scan_pos)
          3'h0, 3'h1: sel_nxt = `CTFS_SEL_ONE;
          3'h2, 3'h3: sel_nxt = `CTFS_SEL_TWO;
          default:    sel_nxt = `CTFS_SEL_THREE;
        endcase
        tag_nxt = (scan_pos < 3'h4) ? scan_pos : 3'h7;
        cal_nxt = (scan_pos > 3'h4);
      end
    end else begin
      cal_nxt = (cal_mode_sel != `CTFS_MODE_NORMAL);
      if (differential_select) begin
        if (input_pair_sel == 2'h3) begin
          forbid_nxt = 1'b1;
        end else begin
          sel_nxt = input_pair_sel + 2'h1;
          tag_nxt = 3'h4 + {1'b0, input_pair_sel};
        end
      end else begin
        sel_nxt = input_pair_sel[1] ? `CTFS_SEL_TWO : `CTFS_SEL_ONE;
        tag_nxt = {1'b0, input_pair_sel};
      end
      if (cal_nxt) begin
        tag_nxt = 3'h7;
      end
    end
  end

  always @* begin
    case (sel_nxt)
      `CTFS_SEL_ONE:   tf_act = channel_transfer_one;
      `CTFS_SEL_TWO:   tf_act = channel_transfer_two;
      `CTFS_SEL_THREE: tf_act = channel_transfer_three;
      default:         tf_act = `CTFS_TF_RESET;
    endcase
  end

  assign ctrl_now    = tf_act;
  assign wr_active   = tf_wr_en && (tf_wr_sel == sel_nxt) && (sel_nxt != `CTFS_SEL_NONE);
  assign ctrl_change = wr_active && (tf_wr_data != ctrl_now);

  // Register file and decode
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_transfer_one   <= `CTFS_TF_RESET;
      channel_transfer_two   <= `CTFS_TF_RESET;
      channel_transfer_three <= `CTFS_TF_RESET;
      active_reg_sel         <= `CTFS_SEL_NONE;
      forbidden              <= 1'b0;
      pga_gain               <= 8'h01;
      unipolar               <= 1'b0;
      dac_connect            <= 1'b0;
      dac_negative           <= 1'b0;
      dac_tenths_pct         <= 11'h000;
      channel_tag            <= 3'h0;
      cal_channel            <= 1'b0;
    end else begin
      if (tf_wr_en) begin
        case (tf_wr_sel)
          `CTFS_SEL_ONE:   channel_transfer_one   <= tf_wr_data;
          `CTFS_SEL_TWO:   channel_transfer_two   <= tf_wr_data;
          `CTFS_SEL_THREE: channel_transfer_three <= tf_wr_data;
          default:         channel_transfer_one   <= channel_transfer_one;
        endcase
      end
      active_reg_sel <= sel_nxt;
      forbidden      <= forbid_nxt;
      channel_tag    <= tag_nxt;
      cal_channel    <= cal_nxt;
      pga_gain       <= 8'h01 << tf_act[`CTFS_GAIN_HI:`CTFS_GAIN_LO];
      unipolar       <= tf_act[`CTFS_POL_BIT];
      dac_negative   <= tf_act[`CTFS_DAC_SIGN];
      dac_connect    <= (tf_act[`CTFS_DAC_MAG_HI:`CTFS_DAC_MAG_LO] != 3'h0);
      dac_tenths_pct <= {8'h00, tf_act[2:0]} * (tf_act[`CTFS_POL_BIT] ?
                        11'd`CTFS_STEP_UNI_TENTHS_PCT : 11'd`CTFS_STEP_BI_TENTHS_PCT);
    end
  end

  // Scan position, restart and ready
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_SETTLE;
      settle_cnt_r <= 16'h0000;
      scan_pos     <= 3'h0;
      mod_reset    <= 1'b1;
      data_ready_n <= 1'b1;
      result_data  <= 18'h00000;
      ctrl_prev_r  <= 7'h00;
      pol_hold_r   <= 1'b0;
    end else begin
      ctrl_prev_r <= {auto_sequence, differential_select, cal_mode_sel, input_pair_sel, 1'b0};
      if (ctrl_change || (ctrl_prev_r != {auto_sequence, differential_select,
          cal_mode_sel, input_pair_sel, 1'b0})) begin
        state_r      <= ST_SETTLE;
        settle_cnt_r <= 16'h0000;
        mod_reset    <= 1'b1;
        data_ready_n <= 1'b1;
        if (ctrl_prev_r[6] != auto_sequence) begin
          scan_pos <= 3'h0;
        end
      end else begin
        case (state_r)
          ST_SETTLE: begin
            mod_reset <= 1'b0;
            if (settle_cnt_r == SETTLE_W - 16'h0001) begin
              state_r <= ST_RUN;
            end else begin
              settle_cnt_r <= settle_cnt_r + 16'h0001;
            end
          end
          ST_RUN: begin
            if (conv_done && !forbidden) begin
              result_data  <= filter_result;
              pol_hold_r   <= unipolar;
              data_ready_n <= 1'b0;
              if (auto_sequence) begin
                scan_pos     <= (scan_pos >= last_pos) ? 3'h0 : scan_pos + 3'h1;
                state_r      <= ST_SETTLE;
                settle_cnt_r <= 16'h0000;
              end
            end
          end
          default: state_r <= ST_SETTLE;
        endcase
      end
    end
  end
endmodule // ctfs_top
`default_nettype wire

//--- hw/ctfs_defs.vh
// Constants for the channel transfer-function select block
// Notes on behaviour
// - in_p1 and in_p2 always use register one
// - in_p3 and in_p4 always use register two
// - in_p5 uses register three; in_p6 common
// - Without scan, pair select picks calibration register
// - Scanning maps both calibration inputs to three
// - Scan with calibration appends offset then gain
// - Active setting change restarts filter, drops ready
// - Inactive channel writes disturb nothing
// - Gain code n gives gain two to n
// - Polarity zero bipolar, one unipolar output scaling
// - Polarity change leaves held result untouched
// - Zero magnitude disconnects the offset DAC
// - Step 8.3 percent bipolar, 16.7 unipolar
// - Normal mode pair select chooses inputs
// - Scan steps inputs then calibration inputs
// - Mode field: normal, offset, gain, reserved
// - Register layout gain, polarity, offset; reset zero
`ifndef CTFS_DEFS_VH
`define CTFS_DEFS_VH
`define CTFS_GAIN_HI      7
`define CTFS_GAIN_LO      5
`define CTFS_POL_BIT      4
`define CTFS_DAC_SIGN     3
`define CTFS_DAC_MAG_HI   2
`define CTFS_DAC_MAG_LO   0
`define CTFS_TF_RESET     8'h00
`define CTFS_MODE_NORMAL  2'h0
`define CTFS_MODE_OFFSET  2'h1
`define CTFS_MODE_GAIN    2'h2
`define CTFS_SEL_ONE      2'h1
`define CTFS_SEL_TWO      2'h2
`define CTFS_SEL_THREE    2'h3
`define CTFS_SEL_NONE     2'h0
`define CTFS_SETTLE_US    100
`define CTFS_CLK_MHZ      40
`define CTFS_STEP_BI_TENTHS_PCT  83
`define CTFS_STEP_UNI_TENTHS_PCT 167
`endif

//--- bench/ctfs_chk.sv
// Assertions for channel transfer-function select
`timescale 1ns/1ps
`default_nettype none
module ctfs_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        tf_wr_en,
  input wire logic        auto_sequence,
  input wire logic        differential_select,
  input wire logic [1:0]  cal_mode_sel,
  input wire logic [1:0]  input_pair_sel,
  input wire logic [7:0]  channel_transfer_one,
  input wire logic [7:0]  channel_transfer_two,
  input wire logic [7:0]  channel_transfer_three,
  input wire logic [1:0]  active_reg_sel,
  input wire logic [7:0]  pga_gain,
  input wire logic        unipolar,
  input wire logic        dac_connect,
  input wire logic        dac_negative,
  input wire logic [10:0] dac_tenths_pct,
  input wire logic        cal_channel,
  input wire logic        mod_reset,
  input wire logic        data_ready_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] w, w_r, f;
  logic [1:0] qc_r;
  wire q = qc_r == 2'h3 && active_reg_sel != 2'h0;
  assign w = {auto_sequence, differential_select, cal_mode_sel, input_pair_sel, active_reg_sel};
  assign f = active_reg_sel == 2'h1 ? channel_transfer_one :
             active_reg_sel == 2'h2 ? channel_transfer_two : channel_transfer_three;
  // Quiet cycles since a write or change
  always @(posedge ref_clk) w_r <= w;
  always @(posedge ref_clk) qc_r <= (!rst_n || tf_wr_en || w != w_r) ? 2'h0 :
                                    qc_r + {1'b0, qc_r != 2'h3};
  property p_rs; $changed(w[7:2]) |=> data_ready_n && mod_reset; endproperty
  a_rs: assert property (p_rs) else $error("no restart");
  property p_gn; q |-> pga_gain == 8'h01 << f[7:5]; endproperty
  a_gn: assert property (p_gn) else $error("gain");
  property p_pl; q |-> unipolar == f[4]; endproperty
  a_pl: assert property (p_pl) else $error("polarity");
  property p_dc; q |-> dac_connect == (f[2:0] != 3'h0) &&
    (!dac_connect || dac_negative == f[3]); endproperty
  a_dc: assert property (p_dc) else $error("dac");
  property p_pc; q |-> dac_tenths_pct == f[2:0] * (f[4] ? 11'h0a7 : 11'h053); endproperty
  a_pc: assert property (p_pc) else $error("step");
  property p_ps; q && w[7:6] == 2'h0 && !w[5] |-> active_reg_sel == {1'b0, w[3]} + 2'h1; endproperty
  a_ps: assert property (p_ps) else $error("pseudo");
  property p_pr; q && w[7:4] == 4'h5 |-> active_reg_sel == w[3:2] + 2'h1; endproperty
  a_pr: assert property (p_pr) else $error("pair");
  property p_sc; q && auto_sequence && cal_channel |-> active_reg_sel == 2'h3; endproperty
  a_sc: assert property (p_sc) else $error("scan");
endmodule // ctfs_chk
bind ctfs_top ctfs_chk u_chk (.*);
`default_nettype wire

//--- bench/ctfs_host.sv
// Host model issuing register writes and settings
`timescale 1ns/1ps
`default_nettype none
module ctfs_host (
  input wire logic       ref_clk,
  output var logic [1:0] tf_wr_sel,
  output var logic       tf_wr_en,
  output var logic [7:0] tf_wr_data,
  output var logic       auto_sequence,
  output var logic       differential_select,
  output var logic [1:0] cal_mode_sel,
  output var logic [1:0] input_pair_sel
);
  initial {tf_wr_sel, tf_wr_en, tf_wr_data, auto_sequence, differential_select,
           cal_mode_sel, input_pair_sel} = 17'h00000;
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    tf_wr_sel <= s;
    tf_wr_data <= d;
    tf_wr_en <= 1'b1;
    @(posedge ref_clk);
    tf_wr_en <= 1'b0;
  endtask
  task automatic mode(input logic [5:0] m);
    @(posedge ref_clk);
    {auto_sequence, differential_select, cal_mode_sel, input_pair_sel} <= m;
  endtask
endmodule // ctfs_host
`default_nettype wire

//--- bench/ctfs_top_tb.sv
// Testbench for channel transfer-function select
`timescale 1ns/1ps
`default_nettype none
module ctfs_top_tb;
  logic ref_clk, rst_n, conv_done, tf_wr_en, auto_sequence, differential_select;
  logic [1:0] tf_wr_sel, cal_mode_sel, input_pair_sel, active_reg_sel;
  logic [7:0] tf_wr_data, channel_transfer_one, channel_transfer_two, channel_transfer_three;
  logic [7:0] pga_gain;
  logic [17:0] filter_result, result_data;
  logic [2:0] scan_pos, channel_tag;
  logic [10:0] dac_tenths_pct;
  logic forbidden, unipolar, dac_connect, dac_negative, cal_channel, mod_reset, data_ready_n;
  int mismatches = 0;
  int num_checks = 0;
  ctfs_top #(.SETTLE_CYC(8)) u_dut (.*);
  ctfs_host u_host (.*);
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conv(input logic [17:0] v);
    repeat (20) @(posedge ref_clk);
    conv_done <= 1'b1;
    filter_result <= v;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic conclude;
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    conv_done = 1'b0;
    filter_result = 18'h00000;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk({pga_gain, channel_transfer_two}, 20'h00100);
    for (int g = 0; g < 8; g++) begin
      u_host.wr(2'h1, {g[2:0], 5'h05});
      repeat (2) @(negedge ref_clk);
      chk({pga_gain, dac_tenths_pct}, {1'b0, 8'h01 << g, 11'h19f});
    end
    u_host.wr(2'h1, 8'h1c);
    repeat (2) @(negedge ref_clk);
    chk({unipolar, dac_negative, dac_tenths_pct}, 20'h01a9c);
    u_host.wr(2'h1, 8'h08);
    repeat (2) @(negedge ref_clk);
    chk(dac_connect, 20'h00000);
    conv(18'h2a5a5);
    chk({data_ready_n, result_data}, 20'h2a5a5);
    u_host.wr(2'h3, 8'hff);
    @(negedge ref_clk);
    chk({data_ready_n, channel_transfer_three}, 20'h000ff);
    u_host.wr(2'h1, 8'h18);
    repeat (2) @(negedge ref_clk);
    chk({data_ready_n, result_data}, 20'h6a5a5);
    for (int p = 0; p < 7; p++) begin
      u_host.mode({1'b0, p[2], 2'h1, p[1:0]});
      repeat (2) @(negedge ref_clk);
      chk(active_reg_sel, p[2] ? p[1:0] + 1 : p[1] + 1);
    end
    u_host.mode(6'h13);
    repeat (2) @(negedge ref_clk);
    chk(forbidden, 20'h00001);
    u_host.mode(6'h34);
    repeat (3) conv(18'h00001);
    @(negedge ref_clk);
    chk({cal_channel, channel_tag, active_reg_sel}, 20'h0003f);
    conclude();
  end
endmodule // ctfs_top_tb
`default_nettype wire
